// File: logic/output_setpoint_pkg.sv
// How it works
// - one mask bit per status bit blocks alert
// - output format mode reads back 17h always
// - writes to format mode rejected, invalid data
// - voltages are 16-bit mantissa, exponent fixed -9
// - setpoint write accepted only within 256..2816
// - mode bit0 low: setpoint default from pin
// - effective target clamped to ceiling, default 5.5V
// - ceiling write outside 256..2817 is invalid data
// - upper margin above lower, in range; 3.4V
// - lower margin below upper, in range; 3.2V
// - margin select picks upper, lower or nominal
// - target changes ramp at slew rate, not on/off
// - slew rate accepts four listed codes only
// - feedback scale accepts F001, F002, F004 only
// - frequency exponent 00001, default 600 kHz code
// - frequency accepts only listed codes
// - store-all copies setpoint to non-volatile memory
// - invalid data: discard, set summary and comms bits
`default_nettype none
package output_setpoint_pkg;

    // command codes
    localparam logic [7:0] CMD_STORE_ALL    = 8'h15;
    localparam logic [7:0] CMD_ALERT_MASK   = 8'h1b;
    localparam logic [7:0] CMD_FORMAT_MODE  = 8'h20;
    localparam logic [7:0] CMD_SETPOINT     = 8'h21;
    localparam logic [7:0] CMD_CEILING      = 8'h24;
    localparam logic [7:0] CMD_MARGIN_UPPER = 8'h25;
    localparam logic [7:0] CMD_MARGIN_LOWER = 8'h26;
    localparam logic [7:0] CMD_SLEW_RATE    = 8'h27;
    localparam logic [7:0] CMD_FB_SCALE     = 8'h29;
    localparam logic [7:0] CMD_FREQ         = 8'h33;
    localparam logic [7:0] CMD_STATUS_SUM   = 8'h78;
    localparam logic [7:0] CMD_STATUS_TEMP  = 8'h7d;
    localparam logic [7:0] CMD_STATUS_COMMS = 8'h7e;
    localparam logic [4:0] STATUS_BASE_HI   = 5'h0f;   // status codes 78h..7fh share upper bits

    // fixed values and field positions
    localparam logic [7:0]  FORMAT_MODE_VALUE = 8'h17;
    localparam int          COMMS_INVALID_BIT = 6;
    localparam int          SUM_COMMS_BIT     = 1;
    localparam int          MODE_SRC_BIT      = 0;

    // mantissa ranges, exponent -9
    localparam logic [15:0] VOUT_MIN         = 16'h0100;   // 256
    localparam logic [15:0] OUTPUT_CEILING_LIMIT_SET     = 16'h0b00;   // 2816
    localparam logic [15:0] OUTPUT_CEILING_LIMIT_CEIL    = 16'h0b01;   // 2817

    // reset values
    localparam logic [15:0] CEILING_RESET    = 16'h0b00;   // 5.5 V
    localparam logic [15:0] MARGIN_UP_RESET  = 16'h06cd;   // 3.4 V
    localparam logic [15:0] MARGIN_LO_RESET  = 16'h0666;   // 3.2 V
    localparam logic [15:0] SLEW_RESET       = 16'hd00d;   // 0.203 mV/us
    localparam logic [15:0] FB_SCALE_RESET   = 16'hf004;   // gain 1
    localparam logic [15:0] FREQ_RESET       = 16'h092c;   // 600 kHz

    // accepted codes
    localparam logic [15:0] SLEW_CODE_0 = 16'hd00d;
    localparam logic [15:0] SLEW_CODE_1 = 16'hd07d;
    localparam logic [15:0] SLEW_CODE_2 = 16'hd0bb;
    localparam logic [15:0] SLEW_CODE_3 = 16'hd258;
    localparam logic [15:0] FB_CODE_0   = 16'hf001;
    localparam logic [15:0] FB_CODE_1   = 16'hf002;
    localparam logic [15:0] FB_CODE_2   = 16'hf004;
    localparam logic [4:0]  FREQ_EXP    = 5'h01;
    localparam logic [10:0] FREQ_M_LOW  = 11'h064;         // 200 kHz
    localparam logic [10:0] FREQ_M_HIGH = 11'h258;         // 1200 kHz
    localparam logic [10:0] FREQ_M_STEP = 11'h019;         // 50 kHz
    localparam logic [10:0] FREQ_M_1300 = 11'h28a;
    localparam logic [10:0] FREQ_M_1400 = 11'h2bc;

    // slew timing: rate lsb 15.625 uV/us against a 1.953125 mV step
    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          RATE_PERIOD_NS = 1000;
    localparam int          TICK_CYCLES    = RATE_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [11:0] RATE_PER_STEP  = 12'h07d;      // 125 rate lsb per output lsb

    // power-up load of the setpoint after the pin synchroniser fills
    localparam logic [1:0]  BOOT_LOAD = 2'h2;
    localparam logic [1:0]  BOOT_DONE = 2'h3;

    // margin selection
    typedef enum logic [1:0] {
        MARGIN_NONE  = 2'b00,
        MARGIN_LOWER = 2'b01,
        MARGIN_UPPER = 2'b10
    } margin_sel_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] data;
    } cmd_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } rsp_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } store_t;

    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    function automatic logic slew_ok(input logic [15:0] c);
        return (c == SLEW_CODE_0) || (c == SLEW_CODE_1) || (c == SLEW_CODE_2) || (c == SLEW_CODE_3);
    endfunction

    function automatic logic fb_ok(input logic [15:0] c);
        return (c == FB_CODE_0) || (c == FB_CODE_1) || (c == FB_CODE_2);
    endfunction

    function automatic logic freq_ok(input logic [15:0] c);
        logic [10:0] m;
        logic [10:0] off;
        m   = c[10:0];
        off = m - FREQ_M_LOW;
        return (c[15:11] == FREQ_EXP) &&
               (((m >= FREQ_M_LOW) && (m <= FREQ_M_HIGH) && ((off % FREQ_M_STEP) == 11'h000)) ||
                (m == FREQ_M_1300) || (m == FREQ_M_1400));
    endfunction

endpackage
`default_nettype wire

// File: logic/alert_mask_store.sv
`timescale 1ns/1ns
`default_nettype none
module alert_mask_store (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       wr_en,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wr_data,
    output var  logic [7:0] rd_data
);
    typedef struct packed {
        logic [7:0][7:0] mem;
        logic [7:0]      rd;
    } mask_state_t;

    mask_state_t s;
    mask_state_t next_s;

    // write one mask byte, read data registered
    always_comb begin
        next_s    = s;
        next_s.rd = s.mem[addr];
        if (wr_en) begin
            next_s.mem[addr] = wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data = s.rd;
endmodule
`default_nettype wire

// File: logic/setpoint_slew_ramp.sv
`timescale 1ns/1ns
`default_nettype none
module setpoint_slew_ramp
    import output_setpoint_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        output_on,
    input  wire logic [15:0] target,
    input  wire logic [10:0] rate,
    output var  logic [15:0] level
);
    typedef struct packed {
        logic [5:0]  tick_cnt;
        logic [11:0] accum;
        logic [15:0] level;
    } ramp_state_t;

    ramp_state_t s;
    ramp_state_t next_s;

    // one microsecond tick adds the rate; each 125 banked moves one step
    always_comb begin
        next_s = s;
        if (s.tick_cnt == 6'(TICK_CYCLES - 1)) begin
            next_s.tick_cnt = '0;
        end else begin
            next_s.tick_cnt = s.tick_cnt + 6'h01;
        end
        if (!output_on) begin
            next_s.level = target;
            next_s.accum = '0;
        end else if (s.level == target) begin
            next_s.accum = '0;
        end else if (s.accum >= RATE_PER_STEP) begin
            next_s.accum = s.accum - RATE_PER_STEP;
            next_s.level = (s.level < target) ? s.level + 16'h0001 : s.level - 16'h0001;
        end else if (s.tick_cnt == 6'(TICK_CYCLES - 1)) begin
            next_s.accum = s.accum + {1'b0, rate};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level = s.level;
endmodule
`default_nettype wire

// File: logic/output_setpoint_command_regs.sv
`timescale 1ns/1ns
`default_nettype none
module output_setpoint_command_regs (
    input  wire logic                         ref_clk,
    input  wire logic                         sys_rst,
    input  wire output_setpoint_pkg::cmd_t    host_cmd,
    output var  output_setpoint_pkg::rsp_t    host_rsp,
    input  wire logic [15:0]                  voltage_select_pin,
    input  wire logic [7:0]                   maker_mode_config,
    input  wire logic [15:0]                  nvm_setpoint,
    input  wire logic [1:0]                   op_margin,
    input  wire logic                         output_on,
    input  wire logic [7:0]                   temp_status,
    input  wire logic                         clear_faults,
    output var  logic                         alert_n,
    output var  logic                         comms_fault_bit,
    output var  logic [15:0]                  vout_ramp,
    output var  logic [15:0]                  output_slew_rate,
    output var  logic [15:0]                  feedback_scale_ratio,
    output var  logic [15:0]                  switching_freq_setpoint,
    output var  output_setpoint_pkg::store_t  nvm_store
);
    import output_setpoint_pkg::*;

    typedef struct packed {
        logic [15:0] pin_s1;
        logic [15:0] pin_s2;
        logic [1:0]  boot;
        logic [15:0] setpoint;
        logic [15:0] ceiling;
        logic [15:0] margin_up;
        logic [15:0] margin_lo;
        logic [15:0] slew;
        logic [15:0] fb_scale;
        logic [15:0] freq;
        logic [7:0]  comms_status;
        logic [7:0]  mask_comms;
        logic [7:0]  mask_temp;
        logic        rd_pend;
        logic [7:0]  rd_code;
        logic [15:0] target;
        logic        alert_n;
        rsp_t        rsp;
        store_t      store;
    } regs_state_t;

    regs_state_t s;
    regs_state_t next_s;
    logic        mask_we;
    logic [2:0]  mask_addr;
    logic [7:0]  mask_rd;
    logic        bad;
    logic [15:0] d;
    logic [15:0] chosen;
    logic        status_code;

    // mask bytes, one per status register
    alert_mask_store u_mask (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (mask_we),
        .addr    (mask_addr),
        .wr_data (host_cmd.data[15:8]),
        .rd_data (mask_rd)
    );

    // with output_on high the level moves toward the clamped target at the programmed rate; with it low the level follows the target directly
    setpoint_slew_ramp u_ramp (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .output_on (output_on),
        .target    (s.target),
        .rate      (s.slew[10:0]),
        .level     (vout_ramp)
    );

    // command decode, checks, status and alert
    always_comb begin
        next_s             = s;
        next_s.rsp.valid   = 1'b0;
        next_s.store.valid = 1'b0;
        bad                = 1'b0;
        mask_we            = 1'b0;
        d                  = host_cmd.data;
        status_code        = (host_cmd.data[7:3] == STATUS_BASE_HI);
        mask_addr          = host_cmd.data[2:0];
        chosen             = s.setpoint;

        // pin code passes two flops before use
        next_s.pin_s1 = voltage_select_pin;
        next_s.pin_s2 = s.pin_s1;

        // setpoint default taken once the synchroniser holds the pin code
        if (s.boot != BOOT_DONE) begin
            next_s.boot = s.boot + 2'h1;
        end
        if (s.boot == BOOT_LOAD) begin
            if (maker_mode_config[MODE_SRC_BIT]) begin
                next_s.setpoint = nvm_setpoint;
            end else begin
                next_s.setpoint = s.pin_s2;
            end
        end

        // writes: a failing check leaves the register untouched
        if (host_cmd.valid && host_cmd.write) begin
            if (host_cmd.code == CMD_ALERT_MASK) begin
                if (status_code) begin
                    mask_we = 1'b1;
                    if (host_cmd.data[7:0] == CMD_STATUS_COMMS) begin
                        next_s.mask_comms = host_cmd.data[15:8];
                    end
                    if (host_cmd.data[7:0] == CMD_STATUS_TEMP) begin
                        next_s.mask_temp = host_cmd.data[15:8];
                    end
                end else begin
                    bad = 1'b1;
                end
            end else if (host_cmd.code == CMD_FORMAT_MODE) begin
                bad = 1'b1;
            end else if (host_cmd.code == CMD_SETPOINT) begin
                if (in_range(d, VOUT_MIN, OUTPUT_CEILING_LIMIT_SET)) begin
                    next_s.setpoint = d;
                end else begin
                    bad = 1'b1;
                end
            end else if (host_cmd.code == CMD_CEILING) begin
                if (in_range(d, VOUT_MIN, OUTPUT_CEILING_LIMIT_CEIL)) begin
                    next_s.ceiling = d;
                end else begin
                    bad = 1'b1;
                end
            end else if (host_cmd.code == CMD_MARGIN_UPPER) begin
                if (in_range(d, VOUT_MIN, OUTPUT_CEILING_LIMIT_SET) && (d > s.margin_lo)) begin
                    next_s.margin_up = d;
                end else begin
                    bad = 1'b1;
                end
            end else if (host_cmd.code == CMD_MARGIN_LOWER) begin
                if (in_range(d, VOUT_MIN, OUTPUT_CEILING_LIMIT_SET) && (d < s.margin_up)) begin
                    next_s.margin_lo = d;
                end else begin
                    bad = 1'b1;
                end
            end else if (host_cmd.code == CMD_SLEW_RATE) begin
                if (slew_ok(d)) begin
                    next_s.slew = d;
                end else begin
                    bad = 1'b1;
                end
            end else if (host_cmd.code == CMD_FB_SCALE) begin
                if (fb_ok(d)) begin
                    next_s.fb_scale = d;
                end else begin
                    bad = 1'b1;
                end
            end else if (host_cmd.code == CMD_FREQ) begin
                if (freq_ok(d)) begin
                    next_s.freq = d;
                end else begin
                    bad = 1'b1;
                end
            end else if (host_cmd.code == CMD_STORE_ALL) begin
                next_s.store.valid = 1'b1;
                next_s.store.data  = s.setpoint;
            end
        end

        // invalid data flag: a new fault wins over a clear in the same cycle
        if (bad) begin
            next_s.comms_status[COMMS_INVALID_BIT] = 1'b1;
        end else if (clear_faults) begin
            next_s.comms_status = '0;
        end

        // reads answer two cycles after the request
        next_s.rd_pend = host_cmd.valid && !host_cmd.write;
        next_s.rd_code = host_cmd.code;
        if (s.rd_pend) begin
            next_s.rsp.valid = 1'b1;
            next_s.rsp.data  = '0;
            if (s.rd_code == CMD_ALERT_MASK) begin
                next_s.rsp.data = {8'h00, mask_rd};
            end else if (s.rd_code == CMD_FORMAT_MODE) begin
                next_s.rsp.data = {8'h00, FORMAT_MODE_VALUE};
            end else if (s.rd_code == CMD_SETPOINT) begin
                next_s.rsp.data = s.setpoint;
            end else if (s.rd_code == CMD_CEILING) begin
                next_s.rsp.data = s.ceiling;
            end else if (s.rd_code == CMD_MARGIN_UPPER) begin
                next_s.rsp.data = s.margin_up;
            end else if (s.rd_code == CMD_MARGIN_LOWER) begin
                next_s.rsp.data = s.margin_lo;
            end else if (s.rd_code == CMD_SLEW_RATE) begin
                next_s.rsp.data = s.slew;
            end else if (s.rd_code == CMD_FB_SCALE) begin
                next_s.rsp.data = s.fb_scale;
            end else if (s.rd_code == CMD_FREQ) begin
                next_s.rsp.data = s.freq;
            end else if (s.rd_code == CMD_STATUS_SUM) begin
                next_s.rsp.data[SUM_COMMS_BIT] = |s.comms_status;
            end else if (s.rd_code == CMD_STATUS_COMMS) begin
                next_s.rsp.data = {8'h00, s.comms_status};
            end
        end

        // margin selection, then the ceiling clamp
        case (margin_sel_t'(op_margin))
            MARGIN_UPPER: chosen = s.margin_up;
            MARGIN_LOWER: chosen = s.margin_lo;
            default:      chosen = s.setpoint;
        endcase
        next_s.target = (chosen > s.ceiling) ? s.ceiling : chosen;

        // alert stays low while any unmasked status bit is set
        next_s.alert_n = !(|(s.comms_status & ~s.mask_comms) |
                           |(temp_status & ~s.mask_temp));
    end

    // state register with documented reset values
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s           <= '0;
            s.ceiling   <= CEILING_RESET;
            s.margin_up <= MARGIN_UP_RESET;
            s.margin_lo <= MARGIN_LO_RESET;
            s.slew      <= SLEW_RESET;
            s.fb_scale  <= FB_SCALE_RESET;
            s.freq      <= FREQ_RESET;
            s.alert_n   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign host_rsp                = s.rsp;
    assign alert_n                 = s.alert_n;
    assign comms_fault_bit         = s.comms_status[COMMS_INVALID_BIT];
    assign output_slew_rate        = s.slew;
    assign feedback_scale_ratio    = s.fb_scale;
    assign switching_freq_setpoint = s.freq;
    assign nvm_store               = s.store;
endmodule
`default_nettype wire

// File: tb/pmbus_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pmbus_host_model (
    input  wire logic                      ref_clk,
    output var  output_setpoint_pkg::cmd_t host_cmd,
    input  wire output_setpoint_pkg::rsp_t host_rsp
);
    import output_setpoint_pkg::*;

    // idle lines carry the inverse of the last request so stale values never match
    initial host_cmd = '0;

    // one request, raised after a falling edge and held across its taking edge
    task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(negedge ref_clk);
        host_cmd = '{valid: 1'b1, write: w, code: c, data: d};
        @(negedge ref_clk);
        host_cmd = '{valid: 1'b0, write: ~w, code: ~c, data: ~d};
    endtask

    // write carries no answer
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        send(1'b1, c, d);
    endtask

    // read answer is a one-cycle pulse raised by the first edge after the taking edge
    task automatic rd(input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
        q = 16'hdead;
        send(1'b0, c, d);
        for (int i = 0; i < 4; i++) begin
            if (host_rsp.valid === 1'b1) begin
                q = host_rsp.data;
                break;
            end
            @(negedge ref_clk);
        end
    endtask
endmodule
`default_nettype wire

// File: tb/output_setpoint_command_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module setpoint_regs_checker (
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    input  wire output_setpoint_pkg::cmd_t   host_cmd,
    input  wire output_setpoint_pkg::rsp_t   host_rsp,
    input  wire logic [7:0]                  temp_status,
    input  wire logic                        alert_n,
    input  wire logic                        comms_fault_bit,
    input  wire logic [15:0]                 output_slew_rate,
    input  wire logic [15:0]                 feedback_scale_ratio,
    input  wire logic [15:0]                 switching_freq_setpoint,
    input  wire output_setpoint_pkg::store_t nvm_store
);
    import output_setpoint_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // write and read requests seen on the command port
    wire logic wr_cmd = host_cmd.valid && host_cmd.write;
    wire logic rd_cmd = host_cmd.valid && !host_cmd.write;
    wire logic slew_in = host_cmd.data inside {16'hd00d, 16'hd07d, 16'hd0bb, 16'hd258};
    wire logic fb_in = host_cmd.data inside {16'hf001, 16'hf002, 16'hf004};

    property p_fmt_read;
        rd_cmd && host_cmd.code == 8'h20 |-> ##2 host_rsp.valid && host_rsp.data == 16'h0017;
    endproperty
    property p_fmt_write;
        wr_cmd && host_cmd.code == 8'h20 |=> comms_fault_bit;
    endproperty
    property p_slew_take;
        wr_cmd && host_cmd.code == 8'h27 && slew_in |=> output_slew_rate == $past(host_cmd.data);
    endproperty
    property p_slew_keep;
        wr_cmd && host_cmd.code == 8'h27 && !slew_in |=> $stable(output_slew_rate) && comms_fault_bit;
    endproperty
    property p_fb_keep;
        wr_cmd && host_cmd.code == 8'h29 && !fb_in |=> $stable(feedback_scale_ratio) && comms_fault_bit;
    endproperty
    property p_freq_keep;
        wr_cmd && host_cmd.code == 8'h33 && host_cmd.data[15:11] != 5'h01
            |=> $stable(switching_freq_setpoint) && comms_fault_bit;
    endproperty
    property p_store;
        wr_cmd && host_cmd.code == 8'h15 |=> nvm_store.valid;
    endproperty
    property p_alert_idle;
        !comms_fault_bit && temp_status == 8'h00 |=> alert_n;
    endproperty

    a_fmt_read: assert property (p_fmt_read) else $error("format read wrong");
    a_fmt_write: assert property (p_fmt_write) else $error("format write not refused");
    a_slew_take: assert property (p_slew_take) else $error("slew code not taken");
    a_slew_keep: assert property (p_slew_keep) else $error("slew code not refused");
    a_fb_keep: assert property (p_fb_keep) else $error("scale code not refused");
    a_freq_keep: assert property (p_freq_keep) else $error("frequency exponent not refused");
    a_store: assert property (p_store) else $error("store pulse missing");
    a_alert_idle: assert property (p_alert_idle) else $error("alert held without cause");

    // main scenarios reached
    c_fmt_read: cover property (rd_cmd && host_cmd.code == 8'h20);
    c_store: cover property (nvm_store.valid);
    c_alert: cover property (!alert_n);
endmodule

bind output_setpoint_command_regs setpoint_regs_checker chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .host_cmd(host_cmd), .host_rsp(host_rsp),
    .temp_status(temp_status), .alert_n(alert_n), .comms_fault_bit(comms_fault_bit),
    .output_slew_rate(output_slew_rate), .feedback_scale_ratio(feedback_scale_ratio),
    .switching_freq_setpoint(switching_freq_setpoint), .nvm_store(nvm_store)
);
`default_nettype wire

// File: tb/tb_output_setpoint_command_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tb_output_setpoint_command_regs;
    import output_setpoint_pkg::*;
    logic        ref_clk, sys_rst, output_on, clear_faults, alert_n, comms_fault_bit;
    logic [15:0] voltage_select_pin, nvm_setpoint, vout_ramp, q;
    logic [15:0] output_slew_rate, feedback_scale_ratio, switching_freq_setpoint;
    logic [7:0]  maker_mode_config, temp_status;
    logic [1:0]  op_margin;
    cmd_t        host_cmd;
    rsp_t        host_rsp;
    store_t      nvm_store;
    int          n_mismatch, n_checks, cyc;
    logic [15:0] slew_c [4] = '{16'hd00d, 16'hd07d, 16'hd0bb, 16'hd258};
    logic [15:0] fb_c [3] = '{16'hf001, 16'hf002, 16'hf004};
    logic [15:0] freq_c [8] = '{16'h0864, 16'h0945, 16'h0a8a, 16'h0abc, 16'h0863, 16'h0a71, 16'h0ac0, 16'h1064};

    output_setpoint_command_regs uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .host_cmd(host_cmd), .host_rsp(host_rsp),
        .voltage_select_pin(voltage_select_pin), .maker_mode_config(maker_mode_config),
        .nvm_setpoint(nvm_setpoint), .op_margin(op_margin), .output_on(output_on),
        .temp_status(temp_status), .clear_faults(clear_faults), .alert_n(alert_n),
        .comms_fault_bit(comms_fault_bit), .vout_ramp(vout_ramp), .output_slew_rate(output_slew_rate),
        .feedback_scale_ratio(feedback_scale_ratio), .switching_freq_setpoint(switching_freq_setpoint),
        .nvm_store(nvm_store)
    );
    pmbus_host_model host (.ref_clk(ref_clk), .host_cmd(host_cmd), .host_rsp(host_rsp));

    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // write, look at the fault flag one edge later, then clear it
    task automatic wr_chk(input logic [7:0] c, input logic [15:0] d, input logic bad);
        host.wr(c, d);
        @(negedge ref_clk);
        chk("comms fault", {15'h0, comms_fault_bit}, {15'h0, bad});
        clear_faults = 1'b1;
        @(negedge ref_clk);
        clear_faults = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] c, input logic [15:0] d, input logic [15:0] exp);
        host.rd(c, d, q);
        chk("read data", q, exp);
    endtask

    // settle, then compare the ramped target
    task automatic ramp_chk(input logic [15:0] exp);
        repeat (4) @(negedge ref_clk);
        chk("ramp level", vout_ramp, exp);
    endtask

    initial begin
        {sys_rst, n_mismatch, n_checks, cyc} = {1'b1, 96'h0};
        {voltage_select_pin, nvm_setpoint, maker_mode_config} = {16'h0300, 16'h0400, 8'h00};
        {op_margin, output_on, temp_status, clear_faults} = '0;
        repeat (5) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge ref_clk);
        rd_chk(8'h20, 16'h0000, 16'h0017);
        rd_chk(8'h21, 16'h0000, 16'h0300);
        rd_chk(8'h24, 16'h0000, 16'h0b00);
        rd_chk(8'h25, 16'h0000, 16'h06cd);
        rd_chk(8'h26, 16'h0000, 16'h0666);
        rd_chk(8'h27, 16'h0000, 16'hd00d);
        rd_chk(8'h29, 16'h0000, 16'hf004);
        rd_chk(8'h33, 16'h0000, 16'h092c);
        rd_chk(8'h40, 16'h0000, 16'h0000);
        wr_chk(8'h20, 16'h0017, 1'b1);
        rd_chk(8'h20, 16'h0000, 16'h0017);
        wr_chk(8'h21, 16'h00ff, 1'b1);
        wr_chk(8'h21, 16'h0b01, 1'b1);
        wr_chk(8'h21, 16'h0100, 1'b0);
        rd_chk(8'h21, 16'h0000, 16'h0100);
        wr_chk(8'h24, 16'h0b02, 1'b1);
        wr_chk(8'h24, 16'h00ff, 1'b1);
        wr_chk(8'h24, 16'h0b01, 1'b0);
        wr_chk(8'h25, 16'h0666, 1'b1);
        wr_chk(8'h25, 16'h0b01, 1'b1);
        wr_chk(8'h26, 16'h06cd, 1'b1);
        wr_chk(8'h26, 16'h00ff, 1'b1);
        rd_chk(8'h26, 16'h0000, 16'h0666);
        for (int i = 0; i < 4; i++) begin
            wr_chk(8'h27, slew_c[i], 1'b0);
            chk("slew", output_slew_rate, slew_c[i]);
        end
        wr_chk(8'h27, 16'hd00e, 1'b1);
        for (int i = 0; i < 3; i++) begin
            wr_chk(8'h29, fb_c[i], 1'b0);
            chk("scale", feedback_scale_ratio, fb_c[i]);
        end
        wr_chk(8'h29, 16'hf003, 1'b1);
        chk("scale", feedback_scale_ratio, 16'hf004);
        for (int i = 0; i < 8; i++) begin
            wr_chk(8'h33, freq_c[i], i > 3);
        end
        chk("frequency", switching_freq_setpoint, 16'h0abc);
        wr_chk(8'h1b, 16'h407d, 1'b0);
        rd_chk(8'h1b, 16'h007d, 16'h0040);
        temp_status = 8'h40;
        repeat (3) @(negedge ref_clk);
        chk("alert masked", {15'h0, alert_n}, 16'h0001);
        temp_status = 8'h41;
        repeat (3) @(negedge ref_clk);
        chk("alert raised", {15'h0, alert_n}, 16'h0000);
        temp_status = 8'h00;
        repeat (3) @(negedge ref_clk);
        chk("alert released", {15'h0, alert_n}, 16'h0001);
        host.wr(8'h20, 16'h0000);
        rd_chk(8'h78, 16'h0000, 16'h0002);
        chk("alert on fault", {15'h0, alert_n}, 16'h0000);
        wr_chk(8'h20, 16'h0000, 1'b1);
        wr_chk(8'h24, 16'h0600, 1'b0);
        op_margin = 2'b10;
        ramp_chk(16'h0600);
        wr_chk(8'h24, 16'h0b01, 1'b0);
        ramp_chk(16'h06cd);
        op_margin = 2'b01;
        ramp_chk(16'h0666);
        op_margin = 2'b00;
        ramp_chk(16'h0100);
        output_on = 1'b1;
        wr_chk(8'h21, 16'h0140, 1'b0);
        repeat (100) @(negedge ref_clk);
        chk("ramp partial", {15'h0, vout_ramp > 16'h0100 && vout_ramp < 16'h0140}, 16'h0001);
        for (int i = 0; i < 3000 && vout_ramp !== 16'h0140; i++) @(negedge ref_clk);
        chk("ramp end", vout_ramp, 16'h0140);
        host.wr(8'h15, 16'h0000);
        chk("store valid", {15'h0, nvm_store.valid}, 16'h0001);
        @(negedge ref_clk);
        chk("store data", nvm_store.data, 16'h0140);
        finish_test();
    end
endmodule
`default_nettype wire
